// ===== fp_port_pkg.sv
// constants and types shared by both ends of the operand port
package fp_port_pkg;
    localparam int HALF_W = 16;
    localparam int WORD_W = 32;
    localparam int BIAS = 127;
    localparam int EXP_FULL = 255;
    // load_select codes
    localparam logic [1:0] LD_NONE = 2'h0;
    localparam logic [1:0] LD_AB = 2'h1;
    localparam logic [1:0] LD_A = 2'h2;
    localparam logic [1:0] LD_B = 2'h3;
    // unload_select codes
    localparam logic [1:0] UL_HIZ = 2'h0;
    localparam logic [1:0] UL_UPPER = 2'h1;
    localparam logic [1:0] UL_LOWER = 2'h2;
    localparam logic [1:0] UL_MODE = 2'h3;
    // function codes
    localparam logic [3:0] FN_MUL = 4'h0;
    localparam logic [3:0] FN_NMUL = 4'h1;
    localparam logic [3:0] FN_PASS_A = 4'h2;
    // mode write: function bit 3 picks the page
    localparam int MW_PAGE = 3;
    localparam int MW_FAST = 0;
    localparam int MW_AFFINE = 1;
    localparam int MW_FLOW = 2;
    // exception codes
    localparam logic [2:0] EX_OK = 3'h0;
    localparam logic [2:0] EX_INX = 3'h1;
    localparam logic [2:0] EX_UNF = 3'h2;
    localparam logic [2:0] EX_UNF_INX = 3'h3;
    localparam logic [2:0] EX_OVF_INX = 3'h5;
    localparam logic [2:0] EX_INV = 3'h6;
    localparam logic [2:0] EX_DENORMAL_CLASS = 3'h7;
    localparam logic [30:0] QNAN = 31'h7FC0_0000;
    localparam logic [30:0] INF_MAG = 31'h7F80_0000;
    localparam logic [30:0] MAX_MAG = 31'h7F7F_FFFF;
    // controller registers
    localparam logic [4:0] A_OPA = 5'h00;
    localparam logic [4:0] A_OPB = 5'h04;
    localparam logic [4:0] A_CMD = 5'h08;
    localparam logic [4:0] A_RES = 5'h0C;
    localparam logic [4:0] A_STAT = 5'h10;
    localparam logic [4:0] A_OPA_INT = 5'h14;
    localparam int CMD_MODE = 4;
    localparam int RES_WAIT = 4;
    typedef enum logic [1:0] {RM_NEAR = 2'b00, RM_ZERO = 2'b01, RM_POS = 2'b10, RM_NEG = 2'b11} round_e;
    typedef enum logic [2:0] {
        CL_ZERO = 3'b000, CL_DENORMAL_CLASS = 3'b001, CL_NORM = 3'b010, CL_INF = 3'b011, CL_NAN = 3'b100
    } fp_class_e;
    typedef struct packed {
        logic sign;
        logic signed [9:0] exp;
        logic [23:0] sa;
        logic [23:0] sb;
        logic force_out;
        logic [31:0] forced;
        logic [2:0] code;
    } st1_s;
    typedef struct packed {
        logic sign;
        logic signed [9:0] exp;
        logic [47:0] prod;
        logic force_out;
        logic [31:0] forced;
        logic [2:0] code;
    } st2_s;
endpackage : fp_port_pkg

// ===== fp_port_if.sv
// operand, control and result signals between controller and multiplier
`timescale 1ns/1ps
interface fp_port_if;
    logic [15:0] operand_a_half_bus;
    logic [15:0] operand_b_half_bus;
    logic [1:0] load_select;
    logic [1:0] unload_select;
    logic [3:0] function_select;
    logic [15:0] result_half_bus;
    logic result_oe_b;
    logic [2:0] exception_code;
    modport dev (
        input operand_a_half_bus, operand_b_half_bus, load_select, unload_select, function_select,
        output result_half_bus, result_oe_b, exception_code
    );
    modport ctl (
        output operand_a_half_bus, operand_b_half_bus, load_select, unload_select, function_select,
        input result_half_bus, result_oe_b, exception_code
    );
endinterface : fp_port_if

// ===== fp_classify.sv
// splits a single-precision word into fields and class
`timescale 1ns/1ps
module fp_classify (
    input wire logic [31:0] i_word,
    output fp_port_pkg::fp_class_e o_class,
    output logic o_sign,
    output logic [23:0] o_signif,
    output logic signed [9:0] o_true_exp
);
    logic [7:0] ef;
    logic [22:0] fr;
    logic hidden;
    always_comb begin
        o_sign = i_word[31];
        ef = i_word[30:23];
        fr = i_word[22:0];
        hidden = (ef != 8'h00);
        o_signif = {hidden, fr};
        o_true_exp = hidden ? 10'(signed'({2'b00, ef}) - 10'(fp_port_pkg::BIAS)) : -10'sd126;
        if (ef == 8'(fp_port_pkg::EXP_FULL)) begin
            o_class = (fr != 23'h0) ? fp_port_pkg::CL_NAN : fp_port_pkg::CL_INF;
        end else if (hidden) begin
            o_class = fp_port_pkg::CL_NORM;
        end else begin
            o_class = (fr != 23'h0) ? fp_port_pkg::CL_DENORMAL_CLASS : fp_port_pkg::CL_ZERO;
        end
    end
endmodule : fp_classify

// ===== fp_mul_port.sv
// multiplier end: operand capture, three-stage datapath, result and status port
// Function
// - operands arrive as two 16-bit halves, upper first
// - upper captured on load, lower next edge
// - result bus carries one selected half
// - registers update each edge, stages when loaded
// - load controls move inputs into processing registers
// - unload controls also enable or float outputs
// - function selects operation and writes mode register
// - status reports overflow, underflow, invalid, inexact, denormal
// - word is sign, 8-bit exponent, 23-bit fraction
// - sign one is negative; zero either sign
// - exponent field is true exponent plus 127
// - hidden bit one only for normalized numbers
// - normal exponents -126..127; smaller are denormal
// - controller supplies sign-extended 24-bit integers
// - upper eight bits copy bit 23
// - affine mode keeps the sign of infinity
// - fast mode flushes denormal inputs and underflows
// - flowthrough makes pipeline registers transparent
// - pipeline keeps up to three operations in flight
// - four selectable rounding modes
// - function code comes with the upper halves
// - IEEE mode flags denormal operands in status
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
module fp_mul_port #(
    parameter int HALF_W = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    fp_port_if.dev port,
    output logic o_mode_fast,
    output logic o_mode_affine,
    output logic o_mode_flow,
    output logic [1:0] o_round_mode
);
    if (HALF_W != fp_port_pkg::HALF_W) begin : g_bad_width
        $error("fp_mul_port supports only 16-bit halves");
    end

    function automatic logic round_up(input logic [1:0] rm, input logic s, input logic l,
                                      input logic g, input logic st);
        case (rm)
            fp_port_pkg::RM_NEAR: round_up = g & (st | l);
            fp_port_pkg::RM_ZERO: round_up = 1'b0;
            fp_port_pkg::RM_POS: round_up = ~s & (g | st);
            default: round_up = s & (g | st);
        endcase
    endfunction : round_up

    // operand capture
    logic [15:0] a_hi, b_hi, next_a_hi, next_b_hi;
    logic [31:0] op_a, op_b, next_op_a, next_op_b;
    logic [1:0] pend, next_pend;
    logic [3:0] fn_in, fn_q, next_fn_in, next_fn_q;
    logic go, next_go;
    always_comb begin
        next_a_hi = a_hi;
        next_b_hi = b_hi;
        next_op_a = op_a;
        next_op_b = op_b;
        next_fn_q = fn_q;
        next_fn_in = port.function_select;
        next_pend = fp_port_pkg::LD_NONE;
        next_go = 1'b0;
        if (pend != fp_port_pkg::LD_NONE) begin
            // lower halves follow on the very next edge; a load here is ignored
            if (pend != fp_port_pkg::LD_B) next_op_a = {a_hi, port.operand_a_half_bus};
            if (pend != fp_port_pkg::LD_A) next_op_b = {b_hi, port.operand_b_half_bus};
            next_fn_q = fn_in;
            next_go = 1'b1;
        end else if (port.load_select != fp_port_pkg::LD_NONE) begin
            next_pend = port.load_select;
            next_a_hi = port.operand_a_half_bus;
            next_b_hi = port.operand_b_half_bus;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            a_hi <= 16'h0000;
            b_hi <= 16'h0000;
            op_a <= 32'h0000_0000;
            op_b <= 32'h0000_0000;
            pend <= fp_port_pkg::LD_NONE;
            fn_in <= 4'h0;
            fn_q <= 4'h0;
            go <= 1'b0;
        end else begin
            a_hi <= next_a_hi;
            b_hi <= next_b_hi;
            op_a <= next_op_a;
            op_b <= next_op_b;
            pend <= next_pend;
            fn_in <= next_fn_in;
            fn_q <= next_fn_q;
            go <= next_go;
        end
    end

    // mode register
    logic fast, affine, flow, next_fast, next_affine, next_flow;
    logic [1:0] rnd, next_rnd;
    always_comb begin
        next_fast = fast;
        next_affine = affine;
        next_flow = flow;
        next_rnd = rnd;
        if (port.unload_select == fp_port_pkg::UL_MODE) begin
            if (port.function_select[fp_port_pkg::MW_PAGE]) begin
                next_rnd = port.function_select[1:0];
            end else begin
                next_fast = port.function_select[fp_port_pkg::MW_FAST];
                next_affine = port.function_select[fp_port_pkg::MW_AFFINE];
                next_flow = port.function_select[fp_port_pkg::MW_FLOW];
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            fast <= 1'b0;
            affine <= 1'b1;
            flow <= 1'b0;
            rnd <= fp_port_pkg::RM_NEAR;
        end else begin
            fast <= next_fast;
            affine <= next_affine;
            flow <= next_flow;
            rnd <= next_rnd;
        end
    end

    // stage 1: classification and exponent sum
    fp_port_pkg::fp_class_e ca, cb;
    logic sgn_a, sgn_b;
    logic [23:0] sig_a, sig_b;
    logic signed [9:0] ex_a, ex_b;
    fp_classify u_cls_a (.i_word(op_a), .o_class(ca), .o_sign(sgn_a), .o_signif(sig_a), .o_true_exp(ex_a));
    fp_classify u_cls_b (.i_word(op_b), .o_class(cb), .o_sign(sgn_b), .o_signif(sig_b), .o_true_exp(ex_b));
    fp_port_pkg::st1_s s1, s1n;
    fp_port_pkg::st2_s s2, s2n;
    fp_port_pkg::st1_s s2src;
    fp_port_pkg::st2_s s3src;
    logic v1, v2, next_v1, next_v2;
    logic za, zb, ia, ib;
    always_comb begin
        s1n = '0;
        s1n.sign = sgn_a ^ sgn_b ^ (fn_q == fp_port_pkg::FN_NMUL);
        s1n.exp = 10'(ex_a + ex_b);
        s1n.sa = sig_a;
        s1n.sb = sig_b;
        s1n.code = fp_port_pkg::EX_OK;
        za = (ca == fp_port_pkg::CL_ZERO) || (fast && ca == fp_port_pkg::CL_DENORMAL_CLASS);
        zb = (cb == fp_port_pkg::CL_ZERO) || (fast && cb == fp_port_pkg::CL_DENORMAL_CLASS);
        ia = (ca == fp_port_pkg::CL_INF);
        ib = (cb == fp_port_pkg::CL_INF);
        s1n.force_out = 1'b1;
        if (fn_q == fp_port_pkg::FN_PASS_A) begin
            s1n.forced = op_a;
        end else if (ca == fp_port_pkg::CL_NAN || cb == fp_port_pkg::CL_NAN || (ia && zb) || (ib && za)) begin
            s1n.forced = {1'b0, fp_port_pkg::QNAN};
            s1n.code = fp_port_pkg::EX_INV;
        end else if (ia || ib) begin
            s1n.forced = {affine & s1n.sign, fp_port_pkg::INF_MAG};
        end else if (!fast && (ca == fp_port_pkg::CL_DENORMAL_CLASS || cb == fp_port_pkg::CL_DENORMAL_CLASS)) begin
            s1n.forced = {s1n.sign, 31'h0000_0000};
            s1n.code = fp_port_pkg::EX_DENORMAL_CLASS;
        end else if (za || zb) begin
            s1n.forced = {s1n.sign, 31'h0000_0000};
        end else begin
            s1n.force_out = 1'b0;
        end
        s2src = flow ? s1n : s1;
        s2n.sign = s2src.sign;
        s2n.exp = s2src.exp;
        s2n.prod = s2src.sa * s2src.sb;
        s2n.force_out = s2src.force_out;
        s2n.forced = s2src.forced;
        s2n.code = s2src.code;
        next_v1 = go;
        next_v2 = flow ? go : v1;
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1 <= '0;
            s2 <= '0;
            v1 <= 1'b0;
            v2 <= 1'b0;
        end else begin
            if (go) s1 <= s1n;
            if (flow ? go : v1) s2 <= s2n;
            v1 <= next_v1;
            v2 <= next_v2;
        end
    end

    // stage 3: normalize, round, pack; then output register
    logic [31:0] res, next_res;
    logic [2:0] code, next_code;
    logic [15:0] half, next_half;
    logic oe_b, next_oe_b;
    logic [23:0] m;
    logic [24:0] mr;
    logic g, st, up;
    logic signed [9:0] be;
    logic do_res;
    always_comb begin
        s3src = flow ? s2n : s2;
        do_res = flow ? go : v2;
        m = s3src.prod[47] ? s3src.prod[47:24] : s3src.prod[46:23];
        g = s3src.prod[47] ? s3src.prod[23] : s3src.prod[22];
        st = s3src.prod[47] ? (|s3src.prod[22:0]) : (|s3src.prod[21:0]);
        up = round_up(rnd, s3src.sign, m[0], g, st);
        mr = {1'b0, m} + {24'h00_0000, up};
        be = 10'(s3src.exp + 10'(fp_port_pkg::BIAS) + {9'h000, s3src.prod[47]} + {9'h000, mr[24]});
        if (mr[24]) m = mr[24:1];
        else m = mr[23:0];
        next_res = {s3src.sign, be[7:0], m[22:0]};
        next_code = (g | st) ? fp_port_pkg::EX_INX : fp_port_pkg::EX_OK;
        if (s3src.force_out) begin
            next_res = s3src.forced;
            next_code = s3src.code;
        end else if (be >= 10'sd255) begin
            next_code = fp_port_pkg::EX_OVF_INX;
            case (rnd)
                fp_port_pkg::RM_NEAR: next_res = {s3src.sign, fp_port_pkg::INF_MAG};
                fp_port_pkg::RM_ZERO: next_res = {s3src.sign, fp_port_pkg::MAX_MAG};
                fp_port_pkg::RM_POS: next_res = {s3src.sign, s3src.sign ? fp_port_pkg::MAX_MAG : fp_port_pkg::INF_MAG};
                default: next_res = {s3src.sign, s3src.sign ? fp_port_pkg::INF_MAG : fp_port_pkg::MAX_MAG};
            endcase
        end else if (be <= 10'sd0) begin
            next_res = {s3src.sign, 31'h0000_0000};
            next_code = fast ? fp_port_pkg::EX_UNF_INX : fp_port_pkg::EX_UNF;
        end
        if (!do_res) begin
            next_res = res;
            next_code = code;
        end
        case (port.unload_select)
            fp_port_pkg::UL_UPPER: next_half = res[31:16];
            fp_port_pkg::UL_LOWER: next_half = res[15:0];
            default: next_half = half;
        endcase
        next_oe_b = !(port.unload_select == fp_port_pkg::UL_UPPER || port.unload_select == fp_port_pkg::UL_LOWER);
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            res <= 32'h0000_0000;
            code <= fp_port_pkg::EX_OK;
            half <= 16'h0000;
            oe_b <= 1'b1;
        end else begin
            res <= next_res;
            code <= next_code;
            half <= next_half;
            oe_b <= next_oe_b;
        end
    end
    assign port.result_half_bus = half;
    assign port.result_oe_b = oe_b;
    assign port.exception_code = code;
    assign o_mode_fast = fast;
    assign o_mode_affine = affine;
    assign o_mode_flow = flow;
    assign o_round_mode = rnd;
endmodule : fp_mul_port

// ===== fp_port_ctl.sv
// controller end: register port for software, drives the operand port
`timescale 1ns/1ps
module fp_port_ctl #(
    parameter int WAIT_CYCLES = fp_port_pkg::RES_WAIT
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    fp_port_if.ctl port,
    input wire logic [4:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata
);
    // fewer than four wait cycles would unload the previous result in pipeline mode
    if (WAIT_CYCLES < fp_port_pkg::RES_WAIT || WAIT_CYCLES > 15) begin : g_bad_wait
        $error("fp_port_ctl WAIT_CYCLES must be 4..15");
    end
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_LOAD_LO = 3'b001, ST_WAIT = 3'b010, ST_UNLD_HI = 3'b011,
        ST_UNLD_LO = 3'b100, ST_UNLD_END = 3'b101
    } ctl_state_e;
    ctl_state_e state, next_state;
    logic [31:0] opa, opb, result, rdata, next_opa, next_opb, next_result, next_rdata;
    logic [2:0] xcode, next_xcode;
    logic [3:0] cnt, next_cnt;
    logic [15:0] a_bus, b_bus, next_a_bus, next_b_bus;
    logic [1:0] ld, ul, next_ld, next_ul;
    logic [3:0] fn, next_fn;
    logic busy;
    always_comb begin
        next_state = state;
        next_opa = opa;
        next_opb = opb;
        next_result = result;
        next_xcode = xcode;
        next_cnt = cnt;
        next_a_bus = a_bus;
        next_b_bus = b_bus;
        next_ld = fp_port_pkg::LD_NONE;
        next_ul = fp_port_pkg::UL_HIZ;
        next_fn = fn;
        busy = (state != ST_IDLE);
        next_rdata = 32'h0000_0000;
        if (i_wr && !busy) begin
            case (i_addr)
                fp_port_pkg::A_OPA: next_opa = i_wdata;
                fp_port_pkg::A_OPB: next_opb = i_wdata;
                fp_port_pkg::A_OPA_INT: next_opa = {{8{i_wdata[23]}}, i_wdata[23:0]};
                fp_port_pkg::A_CMD: begin
                    next_fn = i_wdata[3:0];
                    if (i_wdata[fp_port_pkg::CMD_MODE]) begin
                        next_ul = fp_port_pkg::UL_MODE;
                    end else begin
                        next_ld = fp_port_pkg::LD_AB;
                        next_a_bus = opa[31:16];
                        next_b_bus = opb[31:16];
                        next_state = ST_LOAD_LO;
                    end
                end
                default: ;
            endcase
        end
        if (i_rd) begin
            case (i_addr)
                fp_port_pkg::A_OPA: next_rdata = opa;
                fp_port_pkg::A_OPB: next_rdata = opb;
                fp_port_pkg::A_RES: next_rdata = result;
                fp_port_pkg::A_STAT: next_rdata = {28'h000_0000, xcode, busy};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        case (state)
            // idle keeps whatever a command write chose above
            ST_IDLE: ;
            ST_LOAD_LO: begin
                next_a_bus = opa[15:0];
                next_b_bus = opb[15:0];
                next_cnt = 4'(WAIT_CYCLES);
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                next_cnt = cnt - 4'h1;
                if (cnt == 4'h1) begin
                    next_ul = fp_port_pkg::UL_UPPER;
                    next_state = ST_UNLD_HI;
                end
            end
            ST_UNLD_HI: begin
                next_ul = fp_port_pkg::UL_LOWER;
                next_state = ST_UNLD_LO;
            end
            ST_UNLD_LO: begin
                if (!port.result_oe_b) next_result[31:16] = port.result_half_bus;
                next_state = ST_UNLD_END;
            end
            ST_UNLD_END: begin
                if (!port.result_oe_b) next_result[15:0] = port.result_half_bus;
                next_xcode = port.exception_code;
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ST_IDLE;
            opa <= 32'h0000_0000;
            opb <= 32'h0000_0000;
            result <= 32'h0000_0000;
            rdata <= 32'h0000_0000;
            xcode <= fp_port_pkg::EX_OK;
            cnt <= 4'h0;
            a_bus <= 16'h0000;
            b_bus <= 16'h0000;
            ld <= fp_port_pkg::LD_NONE;
            ul <= fp_port_pkg::UL_HIZ;
            fn <= 4'h0;
        end else begin
            state <= next_state;
            opa <= next_opa;
            opb <= next_opb;
            result <= next_result;
            rdata <= next_rdata;
            xcode <= next_xcode;
            cnt <= next_cnt;
            a_bus <= next_a_bus;
            b_bus <= next_b_bus;
            ld <= next_ld;
            ul <= next_ul;
            fn <= next_fn;
        end
    end
    assign port.operand_a_half_bus = a_bus;
    assign port.operand_b_half_bus = b_bus;
    assign port.load_select = ld;
    assign port.unload_select = ul;
    assign port.function_select = fn;
    assign o_rdata = rdata;
endmodule : fp_port_ctl

// ===== fp_port_sva.sv
// assertions on the operand port between controller and multiplier
`timescale 1ns/1ps
module fp_port_sva (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [15:0] operand_a_half_bus,
    input wire logic [15:0] operand_b_half_bus,
    input wire logic [1:0] load_select,
    input wire logic [1:0] unload_select,
    input wire logic [3:0] function_select,
    input wire logic [15:0] result_half_bus,
    input wire logic result_oe_b,
    input wire logic [2:0] exception_code
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    sequence s_unload;
        unload_select == fp_port_pkg::UL_UPPER ##1 unload_select == fp_port_pkg::UL_LOWER
            ##1 unload_select == fp_port_pkg::UL_HIZ;
    endsequence
    property p_load_pulse;
        load_select != fp_port_pkg::LD_NONE |=> load_select == fp_port_pkg::LD_NONE;
    endproperty
    property p_float;
        unload_select == fp_port_pkg::UL_HIZ |=> result_oe_b;
    endproperty
    property p_drive;
        unload_select == fp_port_pkg::UL_UPPER || unload_select == fp_port_pkg::UL_LOWER |=> !result_oe_b;
    endproperty
    property p_mode_float;
        unload_select == fp_port_pkg::UL_MODE |=> result_oe_b;
    endproperty
    property p_unload_seq;
        s_unload |=> result_oe_b && !$past(result_oe_b) && !$past(result_oe_b, 2);
    endproperty
    property p_half_order;
        unload_select == fp_port_pkg::UL_LOWER |-> $past(unload_select) == fp_port_pkg::UL_UPPER;
    endproperty
    property p_hold;
        result_oe_b && $past(result_oe_b) |-> $stable(result_half_bus);
    endproperty
    property p_code_valid;
        exception_code != 3'h4;
    endproperty
    property p_code_cause;
        $changed(exception_code) |-> $past(load_select, 5) != fp_port_pkg::LD_NONE
            || $past(load_select, 3) != fp_port_pkg::LD_NONE;
    endproperty
    a_load_pulse: assert property (p_load_pulse) else $error("load held past one cycle");
    a_float: assert property (p_float) else $error("bus driven after float request");
    a_drive: assert property (p_drive) else $error("bus not driven after half select");
    a_mode_float: assert property (p_mode_float) else $error("bus driven during mode write");
    a_unload_seq: assert property (p_unload_seq) else $error("unload sequence enable wrong");
    a_half_order: assert property (p_half_order) else $error("lower half before upper");
    a_hold: assert property (p_hold) else $error("floated result changed");
    a_code_valid: assert property (p_code_valid) else $error("unknown exception code");
    a_code_cause: assert property (p_code_cause) else $error("code changed off result edge");
endmodule : fp_port_sva

// ===== test_fp_operand_port_and_formats.sv
// self-checking bench: controller and multiplier joined across the operand port
`timescale 1ns/1ps
module test_fp_operand_port_and_formats;
    logic i_clk;
    logic i_rst_b;
    logic [4:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    logic m_fast;
    logic m_aff;
    logic m_flow;
    logic [1:0] m_rnd;
    logic [31:0] seen;
    int num_errors;
    int checks_done;
    fp_port_if port_if ();
    fp_mul_port fp_mul_port_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .port(port_if), .o_mode_fast(m_fast),
        .o_mode_affine(m_aff), .o_mode_flow(m_flow), .o_round_mode(m_rnd));
    fp_port_ctl fp_port_ctl_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .port(port_if), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
    fp_port_sva fp_port_sva_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .operand_a_half_bus(port_if.operand_a_half_bus), .operand_b_half_bus(port_if.operand_b_half_bus),
        .load_select(port_if.load_select), .unload_select(port_if.unload_select),
        .function_select(port_if.function_select), .result_half_bus(port_if.result_half_bus),
        .result_oe_b(port_if.result_oe_b), .exception_code(port_if.exception_code));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task give_verdict;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [4:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 seen = o_rdata;
    endtask : rd
    task wait_idle;
        int n;
        for (n = 0; n < 40; n++) begin
            rd(fp_port_pkg::A_STAT);
            if (seen[0] === 1'b0) break;
        end
        if (n == 40) begin
            num_errors++;
            give_verdict();
        end
    endtask : wait_idle
    task op(input logic [31:0] a, input logic [31:0] b, input logic [3:0] fn, input logic [31:0] r,
            input logic [2:0] c);
        wr(fp_port_pkg::A_OPA, a);
        wr(fp_port_pkg::A_OPB, b);
        wr(fp_port_pkg::A_CMD, {28'h000_0000, fn});
        wait_idle();
        chk({29'h0, seen[3:1]}, {29'h0, c});
        rd(fp_port_pkg::A_RES);
        chk(seen, r);
    endtask : op
    task mode(input logic [3:0] fn);
        wr(fp_port_pkg::A_CMD, {27'h000_0000, 1'b1, fn});
        wait_idle();
    endtask : mode
    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        give_verdict();
    end
    initial begin
        num_errors = 0;
        checks_done = 0;
        i_rst_b = 1'b0;
        i_addr = 5'h00;
        i_wdata = 32'h0000_0000;
        i_wr = 1'b0;
        i_rd = 1'b0;
        repeat (20) @(posedge i_clk);
        i_rst_b <= 1'b1;
        #1 chk({27'h0, m_fast, m_aff, m_flow, m_rnd}, 32'h0000_0008);
        op(32'h4000_0000, 32'h4040_0000, fp_port_pkg::FN_MUL, 32'h40C0_0000, fp_port_pkg::EX_OK);
        op(32'hBFC0_0000, 32'h4000_0000, fp_port_pkg::FN_MUL, 32'hC040_0000, fp_port_pkg::EX_OK);
        op(32'h4000_0000, 32'h4040_0000, fp_port_pkg::FN_NMUL, 32'hC0C0_0000, fp_port_pkg::EX_OK);
        op(32'h1234_5678, 32'h4040_0000, fp_port_pkg::FN_PASS_A, 32'h1234_5678, fp_port_pkg::EX_OK);
        op(32'h0000_0001, 32'h3F80_0000, fp_port_pkg::FN_MUL, 32'h0000_0000, fp_port_pkg::EX_DENORMAL_CLASS);
        op(32'h0080_0000, 32'h3F00_0000, fp_port_pkg::FN_MUL, 32'h0000_0000, fp_port_pkg::EX_UNF);
        op(32'h7F00_0000, 32'h7F00_0000, fp_port_pkg::FN_MUL, 32'h7F80_0000, fp_port_pkg::EX_OVF_INX);
        op(32'h7F80_0000, 32'h0000_0000, fp_port_pkg::FN_MUL, {1'b0, fp_port_pkg::QNAN}, fp_port_pkg::EX_INV);
        op(32'hFF80_0000, 32'h4000_0000, fp_port_pkg::FN_MUL, 32'hFF80_0000, fp_port_pkg::EX_OK);
        for (int rm = 0; rm < 4; rm++) begin
            mode(4'h8 | 4'(rm));
            chk({30'h0, m_rnd}, 32'(rm));
            op(32'h3F80_0001, 32'hBF80_0001, fp_port_pkg::FN_MUL, (rm == 3) ? 32'hBF80_0003 : 32'hBF80_0002,
                fp_port_pkg::EX_INX);
        end
        mode(4'h1);
        chk({27'h0, m_fast, m_aff, m_flow, m_rnd}, 32'h0000_0013);
        op(32'h0080_0000, 32'h3F00_0000, fp_port_pkg::FN_MUL, 32'h0000_0000, fp_port_pkg::EX_UNF_INX);
        op(32'h0000_0001, 32'h3F80_0000, fp_port_pkg::FN_MUL, 32'h0000_0000, fp_port_pkg::EX_OK);
        op(32'hFF80_0000, 32'h4000_0000, fp_port_pkg::FN_MUL, 32'h7F80_0000, fp_port_pkg::EX_OK);
        mode(4'h4);
        chk({27'h0, m_fast, m_aff, m_flow, m_rnd}, 32'h0000_0007);
        op(32'h4000_0000, 32'h4040_0000, fp_port_pkg::FN_MUL, 32'h40C0_0000, fp_port_pkg::EX_OK);
        wr(fp_port_pkg::A_OPA_INT, 32'h0080_0005);
        rd(fp_port_pkg::A_OPA);
        chk(seen, 32'hFF80_0005);
        wr(fp_port_pkg::A_OPA_INT, 32'hFF12_3456);
        rd(fp_port_pkg::A_OPA);
        chk(seen, 32'h0012_3456);
        rd(5'h1C);
        chk(seen, 32'h0000_0000);
        give_verdict();
    end
endmodule : test_fp_operand_port_and_formats
